//--- rtl/pps_params.svh
// Constants for the per-port power sequencer: timing, class codes, the broadcast bus address.
// Assumes a single clock whose rate is given below in MHz.
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

`define PPS_CLK_MHZ        100
`define PPS_MPS_MIN_MS     6
`define PPS_MPS_WINDOW_MS  320
`define PPS_INRUSH_MS      60
`define PPS_COOL_MS        1000

`define PPS_BCAST_ADDR     7'h7f

`define PPS_AUTO_OFF       3'h0
`define PPS_AUTO_2P_15W    3'h1
`define PPS_AUTO_2P_30W    3'h2
`define PPS_AUTO_4P_30W    3'h3
`define PPS_AUTO_4P_45W    3'h4
`define PPS_AUTO_4P_60W    3'h5
`define PPS_AUTO_4P_75W    3'h6
`define PPS_AUTO_4P_90W    3'h7

`define PPS_CLASS_15W      4'h3
`define PPS_CLASS_30W      4'h4
`define PPS_CLASS_45W      4'h5
`define PPS_CLASS_60W      4'h6
`define PPS_CLASS_75W      4'h7
`define PPS_CLASS_90W      4'h8

`endif

//--- rtl/pps_pkg.sv
// Types shared by the power sequencer and its bench.
// Assumes pps_params.svh supplies the numeric constants.
package pps_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DETECT,
    ST_CLASS,
    ST_POWER_ON,
    ST_POWERED,
    ST_COOL
  } pps_state_t;

  typedef struct packed {
    logic       det_done;
    logic       det_valid;
    logic       cls_done;
    logic       cls_valid;
    logic [3:0] req_class;
    logic       start_fault;
    logic       power_policing_threshold_fault;
    logic       current_limit_threshold_fault;
    logic       load_present;
    logic       host_wr;
    logic       host_det;
    logic       host_cls;
    logic       host_pwr_off;
    logic       pwr_allow;
  } pps_port_in_t;

  typedef struct packed {
    logic       power_en;
    logic       foldback_en;
    logic       det_req;
    logic       cls_req;
    logic       detect_enable_bit;
    logic       cls_en;
    logic       cooling;
    logic [3:0] granted_class;
  } pps_port_out_t;

  typedef struct packed {
    pps_state_t state;
    logic       detect_enable_bit;
    logic       cls_en;
    logic       pend_v;
    logic       pend_det;
    logic       pend_cls;
    logic [3:0] granted;
    logic [31:0] timer;
    logic [31:0] mps_run;
  } pps_port_st_t;

endpackage

//--- rtl/pps_sequencer.sv
// Eight-port power-sourcing sequencer: detect, classify, power, police, cool down.
// Assumes the analog front end reports results as synchronous per-port pulses and levels.
//
// Notes on behaviour
// - Power off on command, disconnect or fault.
// - After disconnect, restart detect/class if enabled.
// - Faults start cool-down; enable writes held off.
// - Cool-down end restarts cycles per enable bits.
// - Power-off command clears detect and class enables.
// - Classify requested classes type-1 through type-4.
// - Foldback at power-on; police and trip faults.
// - Keep power only with 6 ms MPS.
// - Autonomous mode runs ports without any host.
// - Select code sets one allocation for all.
// - Demote classes above the autonomous allocation.
// - Autonomous detects forever; classifies after valid detect.
// - Autonomous powers on after valid classification.
// - Run from ROM, optionally from loaded SRAM.
// - Answer broadcast address during SRAM loading.
`include "pps_params.svh"

module pps_sequencer #(
  parameter int          NPORTS      = 8,
  parameter int unsigned MPS_MIN_CYC = `PPS_MPS_MIN_MS * 1000 * `PPS_CLK_MHZ,
  parameter int unsigned MPS_WIN_CYC = `PPS_MPS_WINDOW_MS * 1000 * `PPS_CLK_MHZ,
  parameter int unsigned INRUSH_CYC  = `PPS_INRUSH_MS * 1000 * `PPS_CLK_MHZ,
  parameter int unsigned COOL_CYC    = `PPS_COOL_MS * 1000 * `PPS_CLK_MHZ
) (
  input  wire logic                            clk,
  input  wire logic                            resetn,
  input  wire logic                            ce,
  input  wire logic [2:0]                      auto_code,
  input  wire logic                            ram_en,
  input  wire logic                            sram_loading,
  input  wire logic [6:0]                      own_addr,
  input  wire logic [6:0]                      i2c_addr,
  input  wire logic                            i2c_addr_vld,
  input  wire pps_pkg::pps_port_in_t [NPORTS-1:0]  port_in,
  output pps_pkg::pps_port_out_t [NPORTS-1:0]      port_out,
  output logic                                 i2c_ack,
  output logic                                 exec_from_sram,
  output logic                                 auto_active
);

  typedef struct packed {
    pps_pkg::pps_port_st_t [NPORTS-1:0]  port;
    pps_pkg::pps_port_out_t [NPORTS-1:0] out;
    logic                               act;
    logic [2:0]                         code;
    logic                               ack;
    logic                               sram;
  } pps_top_st_t;

  pps_top_st_t st_q;
  pps_top_st_t st_d;

  localparam logic [31:0] MPS_MIN = 32'(MPS_MIN_CYC);
  localparam logic [31:0] MPS_WIN = 32'(MPS_WIN_CYC);
  localparam logic [31:0] INRUSH  = 32'(INRUSH_CYC);
  localparam logic [31:0] COOL    = 32'(COOL_CYC);

  // Highest class that the selected autonomous allocation may grant.
  function automatic logic [3:0] class_cap(input logic [2:0] code);
    case (code)
      `PPS_AUTO_2P_15W: class_cap = `PPS_CLASS_15W;
      `PPS_AUTO_2P_30W: class_cap = `PPS_CLASS_30W;
      `PPS_AUTO_4P_30W: class_cap = `PPS_CLASS_30W;
      `PPS_AUTO_4P_45W: class_cap = `PPS_CLASS_45W;
      `PPS_AUTO_4P_60W: class_cap = `PPS_CLASS_60W;
      `PPS_AUTO_4P_75W: class_cap = `PPS_CLASS_75W;
      `PPS_AUTO_4P_90W: class_cap = `PPS_CLASS_90W;
      default:          class_cap = `PPS_CLASS_90W;
    endcase
  endfunction

  always_comb begin
    logic                  autom;
    logic                  fault;
    pps_pkg::pps_port_in_t pi;
    pps_pkg::pps_port_st_t p;
    autom = 1'b0;
    fault = 1'b0;
    pi    = '0;
    p     = '0;
    st_d  = st_q;
    // The select code is sampled on every cycle with ce high; a resistor code is static in practice.
    st_d.code = auto_code;
    st_d.act  = (auto_code != `PPS_AUTO_OFF);
    autom     = (st_q.code != `PPS_AUTO_OFF);
    st_d.sram = ram_en;
    st_d.ack  = i2c_addr_vld && ((i2c_addr == own_addr) ||
                (sram_loading && (i2c_addr == `PPS_BCAST_ADDR)));
    for (int i = 0; i < NPORTS; i++) begin
      pi = port_in[i];
      p  = st_q.port[i];
      fault = 1'b0;
      // Host enable writes, ignored in autonomous mode: applied at once unless the port is cooling down.
      if (!autom && pi.host_wr) begin
        if (p.state == pps_pkg::ST_COOL) begin
          p.pend_v   = 1'b1;
          p.pend_det = pi.host_det;
          p.pend_cls = pi.host_cls;
        end else begin
          p.detect_enable_bit = pi.host_det;
          p.cls_en            = pi.host_cls;
        end
      end
      if (!autom && pi.host_pwr_off) begin
        p.detect_enable_bit = 1'b0;
        p.cls_en            = 1'b0;
        p.pend_v            = 1'b0;
        p.state             = pps_pkg::ST_IDLE;
        p.timer             = '0;
        p.mps_run           = '0;
      end else begin
        case (p.state)
          pps_pkg::ST_IDLE: begin
            p.timer   = '0;
            p.mps_run = '0;
            if (autom || p.detect_enable_bit) begin
              p.state = pps_pkg::ST_DETECT;
            end else if (p.cls_en) begin
              p.state = pps_pkg::ST_CLASS;
            end
          end
          pps_pkg::ST_DETECT: begin
            if (pi.det_done) begin
              if (pi.det_valid && (autom || p.cls_en)) begin
                p.state = pps_pkg::ST_CLASS;
              end else begin
                p.state = pps_pkg::ST_IDLE;
              end
            end
          end
          pps_pkg::ST_CLASS: begin
            if (pi.cls_done) begin
              // Requested class is kept as reported; demotion applies only in autonomous mode.
              p.granted = pi.req_class;
              if (autom && (pi.req_class > class_cap(st_q.code))) begin
                p.granted = class_cap(st_q.code);
              end
              if (pi.cls_valid && (autom || pi.pwr_allow)) begin
                p.state = pps_pkg::ST_POWER_ON;
                p.timer = '0;
              end else begin
                p.state = pps_pkg::ST_IDLE;
              end
            end
          end
          pps_pkg::ST_POWER_ON: begin
            if (pi.start_fault || pi.current_limit_threshold_fault) begin
              fault = 1'b1;
            end else if (p.timer >= INRUSH - 32'h1) begin
              p.state   = pps_pkg::ST_POWERED;
              p.timer   = '0;
              p.mps_run = '0;
            end else begin
              p.timer = p.timer + 32'h1;
            end
          end
          pps_pkg::ST_POWERED: begin
            if (pi.power_policing_threshold_fault || pi.current_limit_threshold_fault) begin
              fault = 1'b1;
            end else begin
              if (!pi.load_present) begin
                p.mps_run = '0;
              end else if (p.mps_run < MPS_MIN) begin
                p.mps_run = p.mps_run + 32'h1;
              end
              // A qualifying stretch of load current restarts the dropout window.
              if (p.mps_run >= MPS_MIN) begin
                p.timer = '0;
              end else if (p.timer >= MPS_WIN - 32'h1) begin
                p.state = pps_pkg::ST_IDLE;
                p.timer = '0;
              end else begin
                p.timer = p.timer + 32'h1;
              end
            end
          end
          pps_pkg::ST_COOL: begin
            if (p.timer >= COOL - 32'h1) begin
              p.state = pps_pkg::ST_IDLE;
              p.timer = '0;
              if (p.pend_v) begin
                p.detect_enable_bit = p.pend_det;
                p.cls_en            = p.pend_cls;
                p.pend_v            = 1'b0;
              end
            end else begin
              p.timer = p.timer + 32'h1;
            end
          end
          default: begin
            p.state = pps_pkg::ST_IDLE;
          end
        endcase
        if (fault) begin
          p.state   = pps_pkg::ST_COOL;
          p.timer   = '0;
          p.mps_run = '0;
        end
      end
      st_d.port[i] = p;
      // Outputs are decoded from the next state so that each one leaves a flip-flop.
      st_d.out[i].power_en          = (p.state == pps_pkg::ST_POWER_ON) ||
                                      (p.state == pps_pkg::ST_POWERED);
      st_d.out[i].foldback_en       = (p.state == pps_pkg::ST_POWER_ON) ||
                                      (p.state == pps_pkg::ST_POWERED);
      st_d.out[i].det_req           = (p.state == pps_pkg::ST_DETECT);
      st_d.out[i].cls_req           = (p.state == pps_pkg::ST_CLASS);
      st_d.out[i].detect_enable_bit = p.detect_enable_bit;
      st_d.out[i].cls_en            = p.cls_en;
      st_d.out[i].cooling           = (p.state == pps_pkg::ST_COOL);
      st_d.out[i].granted_class     = p.granted;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Outputs are plain wiring from the state register.
  always_comb begin
    port_out       = st_q.out;
    i2c_ack        = st_q.ack;
    exec_from_sram = st_q.sram;
    auto_active    = st_q.act;
  end

endmodule // pps_sequencer

//--- testbench/pps_seq_chk.sv
// Concurrent checks on the power sequencer's ports, watching port 0.
// Assumes the single clk domain with resetn synchronous and active low.
module pps_seq_chk #(
  parameter int          NPORTS   = 8,
  parameter int unsigned COOL_CYC = 10
) (
  input wire logic                                clk,
  input wire logic                                resetn,
  input wire logic                                ce,
  input wire logic                                sram_loading,
  input wire logic [6:0]                          own_addr,
  input wire logic [6:0]                          i2c_addr,
  input wire logic                                i2c_addr_vld,
  input wire pps_pkg::pps_port_in_t [NPORTS-1:0]  port_in,
  input wire pps_pkg::pps_port_out_t [NPORTS-1:0] port_out,
  input wire logic                                i2c_ack,
  input wire logic                                auto_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  pps_pkg::pps_port_in_t  i;
  pps_pkg::pps_port_out_t o;
  logic                   hit;
  logic [31:0]            cool_q;
  assign i = port_in[0];
  assign o = port_out[0];
  assign hit = i2c_addr_vld && (i2c_addr == own_addr || (sram_loading && i2c_addr == 7'h7f));
  // Counts enabled cool-down cycles; frozen cycles do not shorten the interval.
  always_ff @(posedge clk) cool_q <= o.cooling ? cool_q + {31'h0, ce} : 32'h0;
  chk_pwr_off_clear: assert property (
    ce && !auto_active && i.host_pwr_off |=> !o.power_en && !o.detect_enable_bit && !o.cls_en)
    else $error("power-off left the port active");
  chk_fault_cool: assert property (
    ce && o.power_en && i.current_limit_threshold_fault && !i.host_pwr_off |=> o.cooling && !o.power_en)
    else $error("current fault did not start cool-down");
  chk_cool_len: assert property (
    $fell(o.cooling) && !$past(i.host_pwr_off) |-> cool_q == COOL_CYC)
    else $error("cool-down length wrong");
  chk_bad_det: assert property (
    ce && o.det_req && i.det_done && !i.det_valid |=> !o.cls_req)
    else $error("classified after invalid detection");
  chk_det_cls: assert property (
    ce && o.det_req && i.det_done && i.det_valid && (o.cls_en || auto_active)
    && !i.host_pwr_off |=> o.cls_req) else $error("valid detection not classified");
  chk_pwr_cause: assert property (
    $rose(o.power_en) |-> $past(o.cls_req)) else $error("power without classification");
  chk_ack_hit: assert property (ce && hit |=> i2c_ack)
    else $error("address match not acknowledged");
  chk_ack_miss: assert property (ce && !hit |=> !i2c_ack)
    else $error("acknowledge without match");
  chk_host_en: assert property (
    ce && !auto_active && i.host_wr && !i.host_pwr_off && !o.cooling |=>
    o.detect_enable_bit == $past(i.host_det) && o.cls_en == $past(i.host_cls))
    else $error("enable write not applied");
endmodule // pps_seq_chk

bind pps_sequencer pps_seq_chk #(.NPORTS(NPORTS), .COOL_CYC(COOL_CYC)) u_chk (
  .clk(clk), .resetn(resetn), .ce(ce), .sram_loading(sram_loading), .own_addr(own_addr),
  .i2c_addr(i2c_addr), .i2c_addr_vld(i2c_addr_vld), .port_in(port_in), .port_out(port_out),
  .i2c_ack(i2c_ack), .auto_active(auto_active));

//--- testbench/pps_pd_model.sv
// Powered device on one port: answers detect and class requests dly+1 cycles after they rise.
// Assumes requests are levels that fall the cycle after the done pulse is taken.
module pps_pd_model (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        det_req,
  input wire logic        cls_req,
  input wire logic        pwr,
  input wire logic        sig_ok,
  input wire logic        load,
  input wire logic [3:0]  cls_val,
  input wire logic [3:0]  dly,
  output logic            det_done,
  output logic            cls_done,
  output logic            vld,
  output logic [3:0]      req_class,
  output logic            load_present
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  always_ff @(posedge clk) begin
    det_done <= 1'b0;
    cls_done <= 1'b0;
    cnt_q <= 4'h0;
    if (rstn && (det_req || cls_req) && !det_done && !cls_done) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= dly) begin
        det_done <= det_req;
        cls_done <= cls_req;
        cnt_q <= 4'h0;
      end
    end
  end
  // Outside a result pulse the lines carry the inverse, so a value sampled outside the pulse is always the wrong one.
  assign vld = (det_done || cls_done) ? sig_ok : ~sig_ok;
  assign req_class = cls_done ? cls_val : ~cls_val;
  assign load_present = pwr & load;
endmodule // pps_pd_model

//--- testbench/tb_top.sv
// Self-checking bench for the power sequencer, port 0 faced by a device model.
// Assumes shortened timing parameters so a run stays under a thousand cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 10, DR = 8, CR = 7, CO = 4;
  logic clk = 1'b0;
  logic resetn, ce, ram_en, sram_loading, vld, sig_ok, load, dd, cd, pv, lp, ack, exe, aut;
  logic [2:0] auto_code;
  logic [6:0] addr;
  logic [3:0] cls_val, dly, rc;
  logic [6:0] at [4] = '{7'h25, 7'h7f, 7'h7f, 7'h26};
  logic [3:0] caps [7] = '{4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  pps_pkg::pps_port_in_t h;
  pps_pkg::pps_port_in_t [7:0] pin;
  pps_pkg::pps_port_out_t [7:0] pout;
  int error_cnt = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  assign pin[0] = {dd, pv, cd, pv, rc, h.start_fault, h.power_policing_threshold_fault, h.current_limit_threshold_fault, lp, h[4:0]};
  assign pin[7:1] = '0;
  pps_sequencer #(.MPS_MIN_CYC(6), .MPS_WIN_CYC(40), .INRUSH_CYC(5), .COOL_CYC(10)) dut (
    .clk(clk), .resetn(resetn), .ce(ce), .auto_code(auto_code), .ram_en(ram_en),
    .sram_loading(sram_loading), .own_addr(7'h25), .i2c_addr(addr), .i2c_addr_vld(vld),
    .port_in(pin), .port_out(pout), .i2c_ack(ack), .exec_from_sram(exe), .auto_active(aut));
  pps_pd_model pd (.clk(clk), .rstn(resetn), .det_req(pout[0].det_req),
    .cls_req(pout[0].cls_req), .pwr(pout[0].power_en), .sig_ok(sig_ok), .load(load),
    .cls_val(cls_val), .dly(dly), .det_done(dd), .cls_done(cd), .vld(pv), .req_class(rc),
    .load_present(lp));
  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rst(input logic [2:0] code);
    resetn = 1'b0;
    auto_code = code;
    cyc(6);
    resetn = 1'b1;
    cyc(1);
  endtask
  // Host command pulse: write strobe, detect, class, power-off.
  task automatic hw(input logic [3:0] v);
    h[4:1] = v;
    cyc(1);
    h[4:1] = 4'h0;
  endtask
  task automatic wt(input int k, input logic v);
    int i;
    for (i = 0; i < 300 && pout[0][k] !== v; i++) cyc(1);
    chk(pout[0][k], v);
  endtask
  initial begin
    {ce, ram_en, sram_loading, vld, sig_ok, load} = 6'h21;
    addr = 7'h25;
    cls_val = 4'h4;
    dly = 4'h0;
    h = '0;
    h.pwr_allow = 1'b1;
    rst(3'h0);
    chk(pout[0], 11'h0);
    chk(pout[7], 11'h0);
    sig_ok = 1'b1;
    hw(4'he);
    wt(PW, 1'b1);
    chk(pout[0].foldback_en, 1'b1);
    chk(pout[0].granted_class, 4'h4);
    repeat (3) begin
      load = 1'b1;
      cyc(6);
      load = 1'b0;
      cyc(30);
    end
    chk(pout[0].power_en, 1'b1);
    dly = 4'hf;
    cyc(15);
    chk(pout[0][PW:DR], 3'h1);
    dly = 4'h0;
    load = 1'b1;
    for (int f = 0; f < 3; f++) begin
      wt(PW, 1'b1);
      if (f > 0) cyc(8);
      {h.start_fault, h.power_policing_threshold_fault, h.current_limit_threshold_fault} = 3'h4 >> f;
      cyc(1);
      {h.start_fault, h.power_policing_threshold_fault, h.current_limit_threshold_fault} = 3'h0;
      chk(pout[0][PW:CO], 7'h07);
    end
    hw(4'ha);
    chk(pout[0][6:5], 2'h3);
    ce = 1'b0;
    cyc(20);
    chk(pout[0][PW:CO], 7'h07);
    ce = 1'b1;
    wt(CO, 1'b0);
    wt(CR, 1'b1);
    chk(pout[0][6:5], 2'h1);
    wt(PW, 1'b1);
    hw(4'hf);
    chk(pout[0][PW:CO], 7'h0);
    cyc(20);
    chk(pout[0][PW:CO], 7'h0);
    vld = 1'b1;
    for (int k = 0; k < 4; k++) begin
      addr = at[k];
      sram_loading = (k > 1);
      ram_en = k[0];
      cyc(1);
      chk({ack, exe}, {k == 0 || k == 2, k[0]});
    end
    vld = 1'b0;
    cls_val = 4'h8;
    h.pwr_allow = 1'b0;
    for (int c = 1; c < 8; c++) begin
      sig_ok = 1'b0;
      rst(c[2:0]);
      cyc(30);
      chk({aut, pout[0].cls_req}, 2'h2);
      chk({pout[7].det_req, pout[1].power_en}, 2'h2);
      sig_ok = 1'b1;
      wt(PW, 1'b1);
      chk(pout[0].granted_class, caps[c-1]);
      hw(4'h1);
      chk(pout[0].power_en, 1'b1);
    end
    give_verdict();
  end
  initial begin
    #200us;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_top
